//--- dlc_consts.svh
// Constants of the display list coprocessor: offsets, fields, resets.
// Assumes inclusion by bare name from files that need the numbers.
`ifndef DLC_CONSTS_SVH
`define DLC_CONSTS_SVH

// ------------------------------------------------------------
// APB register byte offsets
// ------------------------------------------------------------
`define DLC_OFF_CTRL    8'h00
`define DLC_OFF_LIST1   8'h04
`define DLC_OFF_LIST2   8'h08
`define DLC_OFF_JMP1    8'h0C
`define DLC_OFF_JMP2    8'h10
`define DLC_OFF_IRQREQ  8'h14
`define DLC_OFF_STATUS  8'h18

// ------------------------------------------------------------
// Chip register selects seen by move instructions
// ------------------------------------------------------------
`define DLC_SEL_JMP1    8'h44
`define DLC_SEL_JMP2    8'h45
`define DLC_SEL_IRQREQ  8'h4E

// ------------------------------------------------------------
// Instruction word fields, register bits, limits and reset values
// ------------------------------------------------------------
`define DLC_TYPE_BIT    0
`define DLC_BFD_BIT     15
`define DLC_SETCLR_BIT  15
`define DLC_COPIRQ_BIT  4
`define DLC_RUN_BIT     0
`define DLC_HPOS_LAST   9'h0E2
`define DLC_WORD_STEP   2
`define DLC_IRQ_RESET   15'h0000
`define DLC_W_RESET     16'h0000

`endif

//--- dlc_pkg.sv
// Types shared by the display list coprocessor files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dlc_pkg;

   typedef enum logic [2:0] {
      DLC_ST_IDLE,
      DLC_ST_FETCH1,
      DLC_ST_FETCH2,
      DLC_ST_EXEC,
      DLC_ST_WAIT
   } dlc_state_t;

   // One write on the chip register bus
   typedef struct packed {
      logic        wr;
      logic [7:0]  sel;
      logic [15:0] data;
   } dlc_creg_t;

   // Beam position from the display timing logic
   typedef struct packed {
      logic [7:0] vpos;
      logic [8:0] hpos;
   } dlc_beam_t;

endpackage
`default_nettype wire

//--- dlc_beam_cmp.sv
// Masked greater-or-equal compare of beam position against a target.
// Assumes caller forces mask bits that have no enable.
`default_nettype none
`timescale 1ns/100ps

module dlc_beam_cmp #(
   parameter int W = 15
) (
   input  wire logic [W-1:0] beam,
   input  wire logic [W-1:0] target,
   input  wire logic [W-1:0] mask,
   output logic              reached
);

   // ------------------------------------------------------------
   // Masked bits drop out, so they compare as always true
   // ------------------------------------------------------------
   wire logic [W-1:0] beam_m;
   wire logic [W-1:0] target_m;

   assign beam_m   = beam & mask;
   assign target_m = target & mask;
   assign reached  = (beam_m >= target_m);

endmodule
`default_nettype wire

//--- dlc_top.sv
// Display list coprocessor: fetches, decodes and runs list instructions.
// Assumes beam, vblank and blit flags come from logic on pclk, and a
// list memory answering mem_ack while mem_req is held.
`default_nettype none
`timescale 1ns/100ps
`include "dlc_consts.svh"

module dlc_top
   import dlc_pkg::*;
#(
   parameter int AW = 20
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   output logic               mem_req,
   output logic [AW-1:0]      mem_addr,
   input  wire logic          mem_ack,
   input  wire logic [15:0]   mem_rdata,
   input  wire dlc_beam_t     beam,
   input  wire logic          vblank_start,
   input  wire logic          blit_done,
   output dlc_creg_t          creg,
   output logic               copro_irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   dlc_state_t        state_q;
   dlc_state_t        state_d;
   logic [AW-1:0]     pc_q;
   logic [AW-1:0]     pc_d;
   logic [AW-1:0]     first_list_pointer_q;
   logic [AW-1:0]     second_list_pointer_q;
   logic [15:0]       first_instr_word_q;
   logic [15:0]       second_instr_word_q;
   logic              skip_q;
   logic              skip_d;
   logic              run_q;
   logic [14:0]       interrupt_request_reg_q;
   logic [14:0]       irq_d;
   logic [31:0]       prdata_q;
   logic              pready_q;
   logic              pslverr_q;
   logic              mem_req_q;
   logic [AW-1:0]     mem_addr_q;
   dlc_creg_t         creg_q;
   dlc_creg_t         creg_d;
   logic              copro_irq_q;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire logic apb_acc;
   wire logic apb_done;
   wire logic apb_wr;
   wire logic hit_ctrl;
   wire logic hit_list1;
   wire logic hit_list2;
   wire logic hit_jmp1;
   wire logic hit_jmp2;
   wire logic hit_irq;
   wire logic hit_stat;
   wire logic hit_any;
   logic [31:0] rd_mux;

   assign apb_acc   = psel & penable;
   assign apb_done  = apb_acc & pready_q;
   assign apb_wr    = apb_done & pwrite;
   assign hit_ctrl  = (paddr == `DLC_OFF_CTRL);
   assign hit_list1 = (paddr == `DLC_OFF_LIST1);
   assign hit_list2 = (paddr == `DLC_OFF_LIST2);
   assign hit_jmp1  = (paddr == `DLC_OFF_JMP1);
   assign hit_jmp2  = (paddr == `DLC_OFF_JMP2);
   assign hit_irq   = (paddr == `DLC_OFF_IRQREQ);
   assign hit_stat  = (paddr == `DLC_OFF_STATUS);
   assign hit_any   = hit_ctrl | hit_list1 | hit_list2 | hit_jmp1
                    | hit_jmp2 | hit_irq | hit_stat;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[`DLC_RUN_BIT] = run_q;
      end
      if (hit_list1) begin
         rd_mux[AW-1:0] = first_list_pointer_q;
      end
      if (hit_list2) begin
         rd_mux[AW-1:0] = second_list_pointer_q;
      end
      if (hit_irq) begin
         rd_mux[14:0] = interrupt_request_reg_q;
      end
      if (hit_stat) begin
         rd_mux[AW-1:0] = pc_q;
         rd_mux[26:24]  = state_q;
         rd_mux[28]     = skip_q;
      end
   end

   // ------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------
   wire logic        is_move;
   wire logic        is_wait;
   wire logic        is_skip;
   wire logic [7:0]  dest_reg_select;
   wire logic [7:0]  vert_pos_target;
   wire logic [6:0]  horiz_pos_target;
   wire logic [6:0]  row_compare_mask;
   wire logic [6:0]  column_compare_mask;
   wire logic        blit_wait_disable;
   wire logic [8:0]  hpos_lim;
   wire logic [14:0] cmp_beam;
   wire logic [14:0] cmp_target;
   wire logic [14:0] cmp_mask;
   wire logic        beam_reached;
   wire logic        wait_done;

   assign is_move = ~first_instr_word_q[`DLC_TYPE_BIT];
   assign is_wait = first_instr_word_q[`DLC_TYPE_BIT]
                  & ~second_instr_word_q[`DLC_TYPE_BIT];
   assign is_skip = first_instr_word_q[`DLC_TYPE_BIT]
                  & second_instr_word_q[`DLC_TYPE_BIT];

   // Bits 15:9 of a move are never looked at
   assign dest_reg_select     = first_instr_word_q[8:1];
   assign vert_pos_target     = first_instr_word_q[15:8];
   assign horiz_pos_target    = first_instr_word_q[7:1];
   assign row_compare_mask    = second_instr_word_q[14:8];
   assign column_compare_mask = second_instr_word_q[7:1];
   assign blit_wait_disable   = second_instr_word_q[`DLC_BFD_BIT];

   // Beam never passes the last position, so higher targets never hit
   assign hpos_lim = (beam.hpos > `DLC_HPOS_LAST) ? `DLC_HPOS_LAST
                   : beam.hpos;
   assign cmp_beam   = {beam.vpos, hpos_lim[8:2]};
   assign cmp_target = {vert_pos_target, horiz_pos_target};
   assign cmp_mask   = {1'b1, row_compare_mask,
                        column_compare_mask};

   dlc_beam_cmp #(
      .W (15)
   ) u_cmp (
      .beam    (cmp_beam),
      .target  (cmp_target),
      .mask    (cmp_mask),
      .reached (beam_reached)
   );

   // A finished blit is still required unless the wait opts out
   assign wait_done = beam_reached
                    & (blit_wait_disable | blit_done);

   // ------------------------------------------------------------
   // Jumps
   // ------------------------------------------------------------
   wire logic run_move;
   wire logic mv_jmp1;
   wire logic mv_jmp2;
   wire logic mv_irq;
   wire logic do_jmp1;
   wire logic do_jmp2;
   wire logic fetching;
   wire logic fetch_hit;

   assign run_move = (state_q == DLC_ST_EXEC) & is_move & ~skip_q;
   assign mv_jmp1  = run_move & (dest_reg_select == `DLC_SEL_JMP1);
   assign mv_jmp2  = run_move & (dest_reg_select == `DLC_SEL_JMP2);
   assign mv_irq   = run_move & (dest_reg_select == `DLC_SEL_IRQREQ);
   // Vertical blank reload wins over every other jump
   assign do_jmp1  = vblank_start | mv_jmp1
                   | (apb_wr & hit_jmp1);
   assign do_jmp2  = ~do_jmp1
                   & (mv_jmp2 | (apb_wr & hit_jmp2));
   assign fetching = (state_q == DLC_ST_FETCH1)
                   | (state_q == DLC_ST_FETCH2);
   assign fetch_hit = fetching & mem_req_q & mem_ack;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      pc_d    = pc_q;
      skip_d  = skip_q;
      creg_d  = '0;
      case (state_q)
         DLC_ST_IDLE: begin
            state_d = DLC_ST_IDLE;
         end
         DLC_ST_FETCH1: begin
            if (fetch_hit) begin
               pc_d    = pc_q + AW'(`DLC_WORD_STEP);
               state_d = DLC_ST_FETCH2;
            end
         end
         DLC_ST_FETCH2: begin
            if (fetch_hit) begin
               pc_d    = pc_q + AW'(`DLC_WORD_STEP);
               state_d = DLC_ST_EXEC;
            end
         end
         DLC_ST_EXEC: begin
            state_d = DLC_ST_FETCH1;
            if (skip_q) begin
               skip_d = 1'b0;
            end else if (is_move) begin
               creg_d.wr   = 1'b1;
               creg_d.sel  = dest_reg_select;
               creg_d.data = second_instr_word_q;
            end else if (is_skip) begin
               skip_d = beam_reached;
            end else if (is_wait) begin
               state_d = DLC_ST_WAIT;
            end
         end
         DLC_ST_WAIT: begin
            // Stays here on a target that cannot come, until a jump or the vertical blank reload
            if (wait_done) begin
               state_d = DLC_ST_FETCH1;
            end
         end
         default: begin
            state_d = DLC_ST_IDLE;
         end
      endcase
      if (do_jmp1) begin
         pc_d    = first_list_pointer_q;
         skip_d  = 1'b0;
         state_d = DLC_ST_FETCH1;
      end else if (do_jmp2) begin
         pc_d    = second_list_pointer_q;
         skip_d  = 1'b0;
         state_d = DLC_ST_FETCH1;
      end
   end

   // ------------------------------------------------------------
   // Interrupt request register
   // ------------------------------------------------------------
   function automatic logic [14:0] setclr(input logic [14:0] cur,
                                          input logic [15:0] wd);
      logic [14:0] res;
      res = cur;
      if (wd[`DLC_SETCLR_BIT]) begin
         res = cur | wd[14:0];
      end else begin
         res = cur & ~wd[14:0];
      end
      return res;
   endfunction

   // Move applied first, host write on top when both land together
   always_comb begin
      irq_d = interrupt_request_reg_q;
      if (mv_irq) begin
         irq_d = setclr(irq_d, second_instr_word_q);
      end
      if (apb_wr & hit_irq) begin
         irq_d = setclr(irq_d, pwdata[15:0]);
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= DLC_ST_IDLE;
         pc_q    <= '0;
         skip_q  <= 1'b0;
         creg_q  <= '0;
      end else begin
         state_q <= state_d;
         pc_q    <= pc_d;
         skip_q  <= skip_d;
         creg_q  <= creg_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_instr_word_q  <= `DLC_W_RESET;
         second_instr_word_q <= `DLC_W_RESET;
      end else if (fetch_hit) begin
         if (state_q == DLC_ST_FETCH1) begin
            first_instr_word_q <= mem_rdata;
         end else begin
            second_instr_word_q <= mem_rdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_req_q  <= 1'b0;
         mem_addr_q <= '0;
      end else begin
         mem_req_q  <= run_q & ((state_d == DLC_ST_FETCH1)
                              | (state_d == DLC_ST_FETCH2));
         mem_addr_q <= pc_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q                 <= 1'b0;
         first_list_pointer_q  <= '0;
         second_list_pointer_q <= '0;
      end else if (apb_wr) begin
         if (hit_ctrl) begin
            run_q <= pwdata[`DLC_RUN_BIT];
         end
         if (hit_list1) begin
            first_list_pointer_q <= pwdata[AW-1:0];
         end
         if (hit_list2) begin
            second_list_pointer_q <= pwdata[AW-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_request_reg_q <= `DLC_IRQ_RESET;
         copro_irq_q             <= 1'b0;
      end else begin
         interrupt_request_reg_q <= irq_d;
         copro_irq_q             <= irq_d[`DLC_COPIRQ_BIT];
      end
   end

   // Access phase always takes two cycles; answer is stable at pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= apb_acc & ~pready_q;
         pslverr_q <= apb_acc & ~pready_q & ~hit_any;
         if (apb_acc & ~pready_q & ~pwrite) begin
            prdata_q <= rd_mux;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = pslverr_q;
   assign mem_req   = mem_req_q;
   assign mem_addr  = mem_addr_q;
   assign creg      = creg_q;
   assign copro_irq = copro_irq_q;

endmodule
`default_nettype wire

//--- dlc_top_sva.sv
// Concurrent checks on the display list coprocessor top ports.
// Assumes one pclk domain and the port set of dlc_top; bound below.
`timescale 1ns/100ps
`default_nettype none
`include "dlc_consts.svh"
module dlc_top_chk
   import dlc_pkg::*;
#(
   parameter int AW = 20
) (
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [7:0]    paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic          mem_req,
   input wire logic [AW-1:0] mem_addr,
   input wire logic          mem_ack,
   input wire logic [15:0]   mem_rdata,
   input wire dlc_beam_t     beam,
   input wire logic          vblank_start,
   input wire logic          blit_done,
   input wire dlc_creg_t     creg,
   input wire logic          copro_irq
);
   // ------------------------------------------------
   // Shadows of pointers, run bit and fetched words
   // ------------------------------------------------
   logic [31:0] list1_q;
   logic [31:0] list2_q;
   logic        run_q;
   logic [15:0] w1_q;
   logic [15:0] w2_q;
   wire         apb_wr = psel && penable && pready && pwrite && !pslverr;
   wire         jmp1 = (apb_wr && paddr == `DLC_OFF_JMP1)
                    || (creg.wr && creg.sel == `DLC_SEL_JMP1);
   wire         jmp2 = (apb_wr && paddr == `DLC_OFF_JMP2)
                    || (creg.wr && creg.sel == `DLC_SEL_JMP2);
   wire         irq_mv = creg.wr && creg.sel == `DLC_SEL_IRQREQ
                      && creg.data[`DLC_COPIRQ_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         list1_q <= '0;
         list2_q <= '0;
         run_q   <= 1'b0;
         w1_q    <= '0;
         w2_q    <= '0;
      end else begin
         if (apb_wr && paddr == `DLC_OFF_LIST1) list1_q <= pwdata;
         if (apb_wr && paddr == `DLC_OFF_LIST2) list2_q <= pwdata;
         if (apb_wr && paddr == `DLC_OFF_CTRL) run_q <= pwdata[0];
         if (mem_req && mem_ack) begin
            w1_q <= w2_q;
            w2_q <= mem_rdata;
         end
      end
   end

   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_fetch(logic [AW-1:0] a);
      ##[1:4] (mem_req && mem_addr == a);
   endsequence

   AST_MOVE_DATA: assert property (creg.wr |->
      creg.data == w2_q && creg.sel == w1_q[8:1])
      else $error("move wrote wrong select or data");
   AST_MOVE_TYPE: assert property (creg.wr |-> !w1_q[0])
      else $error("register write from a non-move word");
   AST_WR_PULSE: assert property (creg.wr |=> !creg.wr)
      else $error("register write held over two cycles");
   AST_JUMP1: assert property (jmp1 && run_q |->
      s_fetch(list1_q[AW-1:0])) else $error("first jump not taken");
   AST_JUMP2: assert property (jmp2 && run_q |->
      s_fetch(list2_q[AW-1:0])) else $error("second jump not taken");
   AST_VBLANK: assert property (vblank_start && run_q |->
      s_fetch(list1_q[AW-1:0])) else $error("no restart at blank");
   AST_IRQ_SET: assert property (irq_mv && creg.data[15] |->
      ##[1:2] copro_irq) else $error("interrupt not raised");
   AST_IRQ_CLR: assert property (irq_mv && !creg.data[15] |->
      ##[1:2] !copro_irq) else $error("interrupt not cleared");
   AST_WORD_STEP: assert property (mem_req && mem_ack && !psel
      && !vblank_start && !creg.wr && !$past(creg.wr) |=>
      !mem_req || mem_addr == $past(mem_addr) + AW'(2))
      else $error("fetch address did not step by one word");
endmodule

bind dlc_top dlc_top_chk #(.AW(AW)) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
   .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
   .beam(beam), .vblank_start(vblank_start), .blit_done(blit_done),
   .creg(creg), .copro_irq(copro_irq)
);
`default_nettype wire

//--- dlc_list_mem.sv
// List memory model answering word fetches, fast or with stalls.
// Assumes requests held until ack; contents loaded by the bench.
`timescale 1ns/100ps
`default_nettype none
module dlc_list_mem #(
   parameter int AW = 20
) (
   input  wire logic          pclk,
   input  wire logic          slow,
   input  wire logic          mem_req,
   input  wire logic [AW-1:0] mem_addr,
   output logic               mem_ack,
   output logic [15:0]        mem_rdata
);
   logic [15:0] words [0:1023];
   logic [1:0]  dly_q = 2'h0;

   initial mem_ack = 1'b0;
   initial mem_rdata = 16'h0000;

   // Idle data toggles so a stale word is never mistaken for fresh
   always @(posedge pclk) begin
      if (mem_req && !mem_ack && (!slow || dly_q == 2'h3)) begin
         mem_ack   <= 1'b1;
         mem_rdata <= words[mem_addr[10:1]];
         dly_q     <= 2'h0;
      end else begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         dly_q     <= mem_req ? dly_q + 2'h1 : 2'h0;
      end
   end
endmodule
`default_nettype wire

//--- display_list_coprocessor_tb.sv
// Self-checking bench: runs lists from the memory model, drives beam.
// Assumes dlc_top, dlc_list_mem and the bound checker are compiled.
`timescale 1ns/100ps
`default_nettype none
`include "dlc_consts.svh"
module display_list_coprocessor_tb import dlc_pkg::*; ;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, vblank_start = 1'b0, blit_done = 1'b0;
   logic        slow = 1'b0, pready, pslverr, mem_req, mem_ack, copro_irq;
   logic        er;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, r;
   logic [19:0] mem_addr;
   logic [15:0] mem_rdata;
   dlc_beam_t   beam = '0;
   dlc_creg_t   creg;
   logic [23:0] exp_q[$];
   integer      seed = 28, num_errors = 0, num_checks = 0;
   integer      cyc = 0, wp = 0, nwr = 0;

   always #5 pclk = ~pclk;

   dlc_top #(.AW(20)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .beam(beam), .vblank_start(vblank_start), .blit_done(blit_done),
      .creg(creg), .copro_irq(copro_irq));
   dlc_list_mem #(.AW(20)) mem_u (
      .pclk(pclk), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   // ------------------------------------------------
   // Compare, close and bus tasks
   // ------------------------------------------------
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (num_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Called just after a rising edge; result lands in rd and er
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) chk_val(n, 0);
      @(posedge pclk);
   endtask

   task automatic ins(input logic [15:0] a, input logic [15:0] b);
      mem_u.words[wp] = a;
      mem_u.words[wp+1] = b;
      wp += 2;
   endtask

   // Move with random don't-care bits in the first word
   task automatic mv(input logic [7:0] s, input logic [15:0] d);
      logic [6:0] dc;
      dc = 7'($random(seed));
      ins({dc, s, 1'b0}, d);
      exp_q.push_back({s, d});
   endtask

   task automatic wait_wr(input int n);
      int k;
      k = 0;
      while (nwr < n && k < 2000) begin
         @(negedge pclk);
         k++;
      end
      chk_val(nwr, n);
      @(posedge pclk);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   always @(posedge pclk) if (creg.wr === 1'b1) begin
      nwr++;
      chk_val(creg[23:0], exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF);
   end

   // ------------------------------------------------
   // Lists and main sequence
   // ------------------------------------------------
   initial begin
      r = $random(seed);
      wp = 'h80;
      mv(8'h20 + 8'(r[3:0]), r[31:16]);
      ins(16'h4001, 16'h7F00);
      mv(`DLC_SEL_IRQREQ, 16'h8010);
      ins(16'h4001, 16'h7F01);
      ins(16'h0040, 16'hDEAD);
      mv(`DLC_SEL_JMP2, r[15:0]);
      wp = 'h100;
      mv(`DLC_SEL_IRQREQ, 16'h0010);
      ins(16'h7001, 16'h7F01);
      mv(8'h21, r[15:0]);
      ins(16'hFFFF, 16'hFFFE);
      wp = 'h180;
      ins(16'h8001, 16'h8000);
      ins(16'h8071, 16'h80FE);
      mv(8'h22, r[31:16]);
      ins(16'hFFFF, 16'hFFFE);
      idle(2);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `DLC_OFF_IRQREQ, 32'h0);
      chk_val(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk_val({er, rd[30:0]}, 32'h80000000);
      apb(1'b1, `DLC_OFF_LIST1, 32'h100);
      apb(1'b1, `DLC_OFF_LIST2, 32'h200);
      apb(1'b0, `DLC_OFF_LIST1, 32'h0);
      chk_val(rd, 32'h100);
      apb(1'b1, `DLC_OFF_CTRL, 32'h1);
      apb(1'b1, `DLC_OFF_JMP1, r);
      wait_wr(1);
      beam.vpos <= 8'h40;
      idle(40);
      chk_val(nwr, 1);
      blit_done <= 1'b1;
      wait_wr(2);
      idle(3);
      chk_val(copro_irq, 1'b1);
      slow <= 1'b1;
      wait_wr(5);
      idle(3);
      chk_val(copro_irq, 1'b0);
      apb(1'b1, `DLC_OFF_LIST1, 32'h300);
      idle(40);
      chk_val(nwr, 5);
      blit_done <= 1'b0;
      beam.hpos <= 9'h010;
      vblank_start <= 1'b1;
      @(posedge pclk);
      vblank_start <= 1'b0;
      idle(40);
      chk_val(nwr, 5);
      beam.vpos <= 8'h80;
      idle(40);
      chk_val(nwr, 5);
      beam.hpos <= 9'h0E2;
      wait_wr(6);
      idle(20);
      chk_val(exp_q.size(), 0);
      finish_test();
   end
endmodule
`default_nettype wire
